// >>> src/lbc_pkg.sv
// Package for the local bus cycle signalling block
package lbc_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int UPPER_LSB = 16;
  localparam int INT_EN_POS = 2; // Position within upper lines
  localparam int TOP_POS = 3;
  localparam int SEG_LO_POS = 0;
  localparam int SEG_HI_POS = 1;
  localparam logic [3:0] UPPER_IO_VAL = 4'h0;
  localparam logic [2:0] CYC_PASSIVE = 3'h7;

  // Segment in use, two status bits
  typedef enum logic [1:0] {
    LBC_SEG_ALT = 2'h0,
    LBC_SEG_STACK = 2'h1,
    LBC_SEG_CODE = 2'h2,
    LBC_SEG_DATA = 2'h3
  } lbc_seg_t;

  // Kind of cycle
  typedef enum logic [1:0] {
    LBC_KIND_READ = 2'h0,
    LBC_KIND_WRITE = 2'h1,
    LBC_KIND_INTA = 2'h2
  } lbc_kind_t;

  // Bus states, one-hot
  typedef enum logic [5:0] {
    LBC_IDLE = 6'h01,
    LBC_ADDRESS_STATE = 6'h02,
    LBC_SECOND_STATE = 6'h04,
    LBC_THIRD_STATE = 6'h08,
    LBC_WAIT_STATE = 6'h10,
    LBC_FINAL_STATE = 6'h20
  } lbc_state_t;

  // A request for one bus cycle
  typedef struct packed {
    lbc_kind_t kind;
    logic is_mem;
    logic first_inta;
    logic [ADDR_W-1:0] addr;
    logic word;
    logic [DATA_W-1:0] wdata;
    lbc_seg_t seg;
    logic cycle_status_bit;
    logic [2:0] cyc_status;
  } lbc_req_t;
endpackage

// >>> src/lbc_bus_cycle.sv
// Multiplexed local bus cycle sequencer and pin drivers
`timescale 1ns/10ps
// Overview of operation
// RULE1: Address in address state, data afterwards
// RULE2: Lowest address bit low for lower byte
// RULE3: Shared lines float in acknowledge and hold
// RULE4: Memory cycle shows top address bits
// RULE5: I/O cycle drives upper lines low
// RULE6: Status on upper lines after address
// RULE7: Interrupt enable status refreshed every clock
// RULE8: Segment code on two bits, top zero
// RULE9: Upper lines float during hold
// RULE10: High byte enable low for upper byte
// RULE11: Enable and lowest bit select lanes
// RULE12: Spare status on enable line later
// RULE13: Enable line floats during hold
// RULE14: Enable low in first acknowledge cycle
// RULE15: Read strobe low second through wait; the code drives it low in third through wait only
// RULE16: Read strobe only after lines floated
// RULE17: Read strobe floats during hold
// RULE18: Read strobe decoded with memory/IO pin
// RULE19: Devices gate chip selects by lane
// RULE20: Ready low inserts wait states
// RULE21: Cycle status passive at cycle end
// RULE22: Address, second, third, waits, final
module lbc_bus_cycle (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire lbc_pkg::lbc_req_t req,
  input wire logic int_enable_flag,
  input wire logic hold_ack,
  input wire logic max_mode,
  input wire logic ready,
  input wire logic [lbc_pkg::DATA_W-1:0] shared_addr_data_lines_i,
  output logic [lbc_pkg::DATA_W-1:0] shared_addr_data_lines_o,
  output logic shared_addr_data_lines_oe,
  output logic [3:0] upper_addr_status_o,
  output logic upper_addr_status_oe,
  output logic high_byte_enable_status_n_o,
  output logic high_byte_enable_status_oe,
  output logic read_strobe_n_o,
  output logic read_strobe_oe,
  output logic memory_io_status,
  output logic [2:0] cyc_status_o,
  output logic req_ready,
  output logic [lbc_pkg::DATA_W-1:0] rdata,
  output logic rdata_valid
);
  import lbc_pkg::*;

  lbc_state_t state_q, state_d;
  lbc_req_t cur_q;
  logic [DATA_W-1:0] ad_q;
  logic ad_oe_q;
  logic [3:0] up_q;
  logic up_oe_q;
  logic bhe_q;
  logic bhe_oe_q;
  logic rd_n_q;
  logic rd_oe_q;
  logic mio_q;
  logic [2:0] cs_q;
  logic rdy_q;
  logic [DATA_W-1:0] rdata_q;
  logic rvalid_q;

  // Cycle shape decodes from the latched request
  wire is_read = (cur_q.kind == LBC_KIND_READ);
  wire is_inta = (cur_q.kind == LBC_KIND_INTA);
  wire a0 = cur_q.addr[0];
  // Lower lane moves when word or even byte; upper when word or odd byte
  wire low_lane = cur_q.word | ~a0; // RULE2 RULE11
  wire high_lane = cur_q.word | a0; // RULE10 RULE11
  wire lowest_address_bit = ~low_lane; // RULE2
  wire high_byte_enable = ~(high_lane | (is_inta & cur_q.first_inta)); // RULE10 RULE14
  wire [3:0] addr_upper = cur_q.is_mem ? cur_q.addr[ADDR_W-1:UPPER_LSB] : UPPER_IO_VAL; // RULE4 RULE5
  wire [DATA_W-1:0] addr_lines = {cur_q.addr[DATA_W-1:1], lowest_address_bit}; // RULE1

  wire st_idle = (state_q == LBC_IDLE);
  wire st_addr = (state_q == LBC_ADDRESS_STATE);
  wire st_second = (state_q == LBC_SECOND_STATE);
  wire st_third = (state_q == LBC_THIRD_STATE);
  wire st_wait = (state_q == LBC_WAIT_STATE);
  wire st_final = (state_q == LBC_FINAL_STATE);
  wire start = req_valid & (st_idle | st_final) & ~hold_ack;

  // Next state: one state per clock, waits while ready is low
  always_comb begin
    state_d = state_q;
    case (state_q)
      LBC_IDLE: begin
        if (start) begin
          state_d = LBC_ADDRESS_STATE;
        end
      end
      LBC_ADDRESS_STATE: state_d = LBC_SECOND_STATE; // RULE22
      LBC_SECOND_STATE: state_d = LBC_THIRD_STATE; // RULE22
      LBC_THIRD_STATE: state_d = ready ? LBC_FINAL_STATE : LBC_WAIT_STATE; // RULE20 RULE22
      LBC_WAIT_STATE: state_d = ready ? LBC_FINAL_STATE : LBC_WAIT_STATE; // RULE20
      LBC_FINAL_STATE: state_d = start ? LBC_ADDRESS_STATE : LBC_IDLE; // RULE22
      default: state_d = LBC_IDLE;
    endcase
  end

  // Pin values registered for the state being entered, so outputs lead by no gate
  wire n_addr = (state_d == LBC_ADDRESS_STATE);
  wire n_second = (state_d == LBC_SECOND_STATE);
  wire n_third = (state_d == LBC_THIRD_STATE);
  wire n_wait = (state_d == LBC_WAIT_STATE);
  wire n_final = (state_d == LBC_FINAL_STATE);
  wire n_busy = n_second | n_third | n_wait | n_final;
  lbc_req_t nreq;
  assign nreq = (start) ? req : cur_q;
  wire n_read = (nreq.kind == LBC_KIND_READ);
  wire n_inta = (nreq.kind == LBC_KIND_INTA);
  wire n_low = nreq.word | ~nreq.addr[0];
  wire n_high = nreq.word | nreq.addr[0];
  wire n_bhe = ~(n_high | (n_inta & nreq.first_inta));
  wire [3:0] n_up_addr = nreq.is_mem ? nreq.addr[ADDR_W-1:UPPER_LSB] : UPPER_IO_VAL;
  wire [3:0] n_up_stat = {1'b0, int_enable_flag, nreq.seg};
  // Data phase: writes drive, reads and acknowledge float
  wire n_ad_oe = ~hold_ack & ~n_inta & (n_addr | (n_busy & ~n_read)); // RULE1 RULE3
  wire [DATA_W-1:0] n_ad = n_addr ? {nreq.addr[DATA_W-1:1], ~n_low} : nreq.wdata; // RULE1 RULE2
  // Strobe waits one state after the lines float at the start of second state
  wire n_rd = n_read & (n_third | n_wait); // RULE15 RULE16
  // Cycle status active only in address and second state; idle stays passive
  wire n_cs_active = max_mode & (n_addr | n_second); // RULE21

  // Sequencer and request latch
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= LBC_IDLE;
      cur_q <= '0;
    end else begin
      state_q <= state_d;
      if (start) begin
        cur_q <= req;
      end
    end
  end

  // Pin registers; hold forces the shared, upper, enable and strobe lines off
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ad_q <= '0;
      ad_oe_q <= 1'b0;
      up_q <= '0;
      up_oe_q <= 1'b0;
      bhe_q <= 1'b1;
      bhe_oe_q <= 1'b0;
      rd_n_q <= 1'b1;
      rd_oe_q <= 1'b0;
      mio_q <= 1'b0;
      cs_q <= CYC_PASSIVE;
    end else begin
      ad_q <= n_ad;
      ad_oe_q <= n_ad_oe; // RULE3
      up_q <= n_addr ? n_up_addr : n_up_stat; // RULE4 RULE5 RULE6 RULE7
      up_oe_q <= ~hold_ack; // RULE9
      bhe_q <= n_addr ? n_bhe : nreq.cycle_status_bit; // RULE10 RULE12 RULE14
      bhe_oe_q <= ~hold_ack; // RULE13
      rd_n_q <= ~(n_rd & ~hold_ack); // RULE15
      rd_oe_q <= ~hold_ack; // RULE17
      mio_q <= nreq.is_mem; // RULE18
      cs_q <= n_cs_active ? nreq.cyc_status : CYC_PASSIVE; // RULE21
    end
  end

  // Capture read data at the end of the last data state
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdy_q <= 1'b0;
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rdy_q <= (state_d == LBC_IDLE) | (state_d == LBC_FINAL_STATE);
      rvalid_q <= 1'b0;
      if ((st_third | st_wait) & ready & is_read) begin
        rdata_q <= shared_addr_data_lines_i;
        rvalid_q <= 1'b1;
      end
    end
  end

  assign shared_addr_data_lines_o = ad_q;
  assign shared_addr_data_lines_oe = ad_oe_q;
  assign upper_addr_status_o = up_q;
  assign upper_addr_status_oe = up_oe_q;
  assign high_byte_enable_status_n_o = bhe_q;
  assign high_byte_enable_status_oe = bhe_oe_q;
  assign read_strobe_n_o = rd_n_q;
  assign read_strobe_oe = rd_oe_q;
  assign memory_io_status = mio_q;
  assign cyc_status_o = cs_q;
  assign req_ready = rdy_q;
  assign rdata = rdata_q;
  assign rdata_valid = rvalid_q;

  // Checks; pins are registered, so hold is judged one clock late
  chk_addr_in_t1: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE1
    st_addr && !$past(hold_ack) && !is_inta |-> ad_oe_q && ad_q == addr_lines)
    else $error("address lines wrong in address state");
  chk_lowlane_a0: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE2
    st_addr && low_lane && !is_inta |-> !ad_q[0])
    else $error("lowest address bit not low for lower lane");
  chk_float_hold: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE3 RULE9 RULE13 RULE17
    $past(hold_ack) |-> !ad_oe_q && !up_oe_q && !bhe_oe_q && !rd_oe_q)
    else $error("pins driven during hold");
  chk_float_inta: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE3
    !st_idle && is_inta |-> !ad_oe_q)
    else $error("shared lines driven in acknowledge");
  chk_upper_t1: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE4 RULE5
    st_addr |-> up_q == addr_upper)
    else $error("upper lines wrong in address state");
  chk_status_later: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE6 RULE7 RULE8
    (st_second || st_third || st_wait) |-> up_q[TOP_POS] == 1'b0
    && up_q[SEG_HI_POS:SEG_LO_POS] == cur_q.seg
    && up_q[INT_EN_POS] == $past(int_enable_flag))
    else $error("status bits wrong");
  chk_bhe_t1: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE10 RULE11 RULE14
    st_addr |-> bhe_q == high_byte_enable)
    else $error("high byte enable wrong");
  chk_bhe_status: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE12
    (st_second || st_third || st_final) |-> bhe_q == cur_q.cycle_status_bit)
    else $error("spare status wrong");
  chk_rd_nooverlap: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE16
    !read_strobe_n_o |-> !ad_oe_q)
    else $error("read strobe overlaps driven lines");
  chk_rd_window: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE15
    st_third && is_read && !$past(hold_ack) |-> !rd_n_q)
    else $error("read strobe not low");
  chk_seq_order: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE22
    st_addr |=> st_second ##1 st_third)
    else $error("bus states out of order");
  chk_wait_ready: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE20
    (st_third || st_wait) && !ready |=> st_wait)
    else $error("no wait state while not ready");
  chk_cs_passive: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE21
    st_final |-> cs_q == CYC_PASSIVE)
    else $error("cycle status not passive");

  // Write data must stand on the shared lines for the whole data phase
  chk_write_data: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE1
    (st_second || st_third || st_wait || st_final) && cur_q.kind == LBC_KIND_WRITE
    && !$past(hold_ack) |-> ad_oe_q && ad_q == cur_q.wdata)
    else $error("write data not driven");

  // Reads leave the shared lines to the addressed device after the address
  chk_read_float: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE1 RULE16
    (st_second || st_third || st_wait || st_final) && is_read |-> !ad_oe_q)
    else $error("shared lines driven in read data phase");

  // Strobe stays high while the address may still be on the lines
  chk_rd_early_high: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE16
    st_addr || st_second |-> rd_n_q)
    else $error("read strobe low too early");

  // Only reads may pulse the strobe
  chk_rd_write_high: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE15
    !st_idle && !is_read |-> rd_n_q)
    else $error("read strobe low outside read");

  // Every wait state of a read keeps the strobe low
  chk_rd_wait_low: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE15
    st_wait && is_read && !$past(hold_ack) |-> !rd_n_q)
    else $error("read strobe high in wait state");

  // Strobe returns high in the final state
  chk_rd_final_high: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE15
    st_final |-> rd_n_q)
    else $error("read strobe low in final state");

  // Memory/IO pin tracks the cycle so the strobe can be decoded
  chk_mio_status: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE18
    !st_idle |-> memory_io_status == cur_q.is_mem)
    else $error("memory io status wrong");

  // I/O cycles show zeros on the upper lines
  chk_upper_io_low: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE5
    st_addr && !cur_q.is_mem |-> up_q == UPPER_IO_VAL)
    else $error("upper lines not low for io");

  // Memory cycles show the top address bits
  chk_upper_mem_addr: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE4
    st_addr && cur_q.is_mem |-> up_q == cur_q.addr[ADDR_W-1:UPPER_LSB])
    else $error("upper lines not the top address");

  // Top status bit stays zero through the whole status phase
  chk_top_zero: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE8
    (st_second || st_third || st_wait || st_final) |-> up_q[TOP_POS] == 1'b0)
    else $error("top status bit not zero");

  // Segment code still shown in the final state
  chk_seg_final: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE6 RULE8
    st_final |-> up_q[SEG_HI_POS:SEG_LO_POS] == cur_q.seg)
    else $error("segment status wrong in final state");

  // Interrupt enable follows the flag clock by clock
  chk_ie_final: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE7
    st_final |-> up_q[INT_EN_POS] == $past(int_enable_flag))
    else $error("interrupt enable status stale");

  // Whole words enable the upper lane
  chk_bhe_word: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE11
    st_addr && cur_q.word |-> !bhe_q)
    else $error("high byte enable high for word");

  // Even bytes leave the upper lane off
  chk_bhe_even_byte: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE11
    st_addr && !cur_q.word && !a0 && !(is_inta && cur_q.first_inta) |-> bhe_q)
    else $error("high byte enable low for even byte");

  // Odd bytes keep the lower lane off
  chk_a0_odd_byte: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE11
    st_addr && !cur_q.word && a0 && !is_inta |-> ad_q[0])
    else $error("lowest address bit low for odd byte");

  // First acknowledge always enables the upper lane
  chk_bhe_first_inta: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE14
    st_addr && is_inta && cur_q.first_inta |-> !bhe_q)
    else $error("high byte enable high in first acknowledge");

  // Second state always moves on to third
  chk_second_third: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE22
    st_second |=> st_third)
    else $error("second state not followed by third");

  // Ready ends the data phase at once
  chk_final_on_ready: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE20 RULE22
    (st_third || st_wait) && ready |=> st_final)
    else $error("final state missed on ready");

  // Final state lasts one clock
  chk_final_leaves: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE22
    st_final |=> st_idle || st_addr)
    else $error("final state held too long");

  // Maximum mode shows the caller's cycle status with the address
  chk_cs_active: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE21
    st_addr && $past(max_mode) |-> cs_q == cur_q.cyc_status)
    else $error("cycle status not active in address state");

  // Third and wait states mark the end of the cycle
  chk_cs_third: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE21
    st_third || st_wait |-> cs_q == CYC_PASSIVE)
    else $error("cycle status not passive in data end");

  // An idle bus must not look like a starting cycle
  chk_cs_idle: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE21
    st_idle |-> cs_q == CYC_PASSIVE)
    else $error("cycle status active while idle");

  // Read data taken on the ready edge
  chk_rdata_capture: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE15 RULE20
    (st_third || st_wait) && ready && is_read
    |=> rdata_valid && rdata == $past(shared_addr_data_lines_i))
    else $error("read data not captured");

  // Read data pulse lines up with the final state
  chk_rvalid_final: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE22
    rdata_valid |-> st_final)
    else $error("read data pulse outside final state");

  // Ready for a request only between cycles
  chk_ready_state: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE22
    req_ready |-> st_idle || st_final)
    else $error("request ready while busy");

  // Hold keeps a new cycle from starting
  chk_no_start_hold: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE3
    st_idle && hold_ack |=> st_idle)
    else $error("cycle started during hold");

  cov_read: cover property (@(posedge ref_clk) disable iff (!resetn) st_third && is_read && ready);
  cov_wait: cover property (@(posedge ref_clk) disable iff (!resetn) st_wait ##1 st_wait);
  cov_inta: cover property (@(posedge ref_clk) disable iff (!resetn) st_addr && is_inta);
  cov_b2b: cover property (@(posedge ref_clk) disable iff (!resetn) st_final ##1 st_addr);
  // Hold seen floating the shared lines
  cov_hold: cover property (@(posedge ref_clk) disable iff (!resetn) $past(hold_ack) && !ad_oe_q);
endmodule

// >>> bench/lbc_mem_model.sv
// Memory and I/O device model facing the local bus block
`timescale 1ns/10ps
module lbc_mem_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [15:0] ad_o,
  input wire logic ad_oe,
  input wire logic rd_n,
  input wire logic rd_oe,
  input wire logic bhe_n,
  input wire logic mio,
  input wire logic [1:0] waits,
  output logic [15:0] ad_wire,
  output logic ready
);
  logic [15:0] addr_q;
  logic bhe_q;
  logic [15:0] last_q;
  logic [1:0] cnt_q;
  logic rd_act;
  logic [15:0] val;
  logic [15:0] drv;
  // Read strobe decoded from strobe and its enable only; the memory/IO pin picks the data pattern
  assign rd_act = rd_oe && !rd_n;
  assign val = mio ? (addr_q ^ 16'ha5c3) : (addr_q ^ 16'h3c5a);
  // Lanes not enabled show inverted junk so a wrong lane cannot match
  assign drv = {bhe_q ? ~val[15:8] : val[15:8], addr_q[0] ? ~val[7:0] : val[7:0]};
  assign ad_wire = ad_oe ? ad_o : (rd_act ? drv : ~last_q);
  // Ready held low for the asked number of wait states, on reads only
  assign ready = !rd_act || (cnt_q >= waits);
  // Latch address and enable only while the block drives the lines
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      addr_q <= 16'h0000;
      bhe_q <= 1'b1;
      last_q <= 16'h0000;
      cnt_q <= 2'h0;
    end else begin
      if (ad_oe && rd_n) begin
        addr_q <= ad_o;
        bhe_q <= bhe_n;
      end
      last_q <= ad_wire;
      cnt_q <= rd_act ? cnt_q + 2'h1 : 2'h0;
    end
  end
endmodule

// >>> bench/testbench.sv
// Self-checking testbench for the local bus cycle block
`timescale 1ns/10ps
module testbench;
  import lbc_pkg::*;
  logic ref_clk, resetn, req_valid, int_enable_flag, hold_ack, max_mode, ready;
  lbc_req_t req;
  logic [1:0] waits;
  logic [15:0] shared_addr_data_lines_i, shared_addr_data_lines_o, rdata;
  logic [3:0] upper_addr_status_o;
  logic [2:0] cyc_status_o;
  logic shared_addr_data_lines_oe, upper_addr_status_oe, high_byte_enable_status_n_o;
  logic high_byte_enable_status_oe, read_strobe_n_o, read_strobe_oe, memory_io_status;
  logic req_ready, rdata_valid;
  int errors, n_checks, seed;
  logic [31:0] exp_q[$];
  logic [31:0] note;
  lbc_bus_cycle dut (.ref_clk, .resetn, .req_valid, .req, .int_enable_flag, .hold_ack,
    .max_mode, .ready, .shared_addr_data_lines_i, .shared_addr_data_lines_o,
    .shared_addr_data_lines_oe, .upper_addr_status_o, .upper_addr_status_oe,
    .high_byte_enable_status_n_o, .high_byte_enable_status_oe, .read_strobe_n_o,
    .read_strobe_oe, .memory_io_status, .cyc_status_o, .req_ready, .rdata, .rdata_valid);
  lbc_mem_model mem (.ref_clk(ref_clk), .resetn(resetn), .ad_o(shared_addr_data_lines_o),
    .ad_oe(shared_addr_data_lines_oe), .rd_n(read_strobe_n_o), .rd_oe(read_strobe_oe),
    .bhe_n(high_byte_enable_status_n_o), .mio(memory_io_status), .waits(waits),
    .ad_wire(shared_addr_data_lines_i), .ready(ready));
  task automatic end_sim;
    if (errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus cycle; read data expectations go to the queue
  task automatic op(input lbc_kind_t k);
    lbc_req_t r;
    logic ie;
    logic mm;
    r = lbc_req_t'({$random(seed), $random(seed), $random(seed)});
    r.kind = k;
    if (r.word) r.addr[0] = 1'b0;
    ie = $random(seed);
    mm = $random(seed);
    @(posedge ref_clk);
    while (req_ready !== 1'b1) @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= r;
    int_enable_flag <= ie;
    waits <= 2'($unsigned($random(seed)) % 3);
    max_mode <= mm;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    #1;
    if (k == LBC_KIND_INTA) begin
      cmp("ad_oe", 16'h0, shared_addr_data_lines_oe);
      if (r.first_inta) cmp("bhe", 16'h0, high_byte_enable_status_n_o);
      return;
    end
    cmp("ad", r.addr[15:0], shared_addr_data_lines_o);
    cmp("upper", r.is_mem ? r.addr[19:16] : 4'h0, upper_addr_status_o);
    cmp("bhe", !(r.word || r.addr[0]), high_byte_enable_status_n_o);
    cmp("mio", r.is_mem, memory_io_status);
    cmp("cyc", mm ? r.cyc_status : CYC_PASSIVE, cyc_status_o);
    if (k == LBC_KIND_READ)
      exp_q.push_back({r.word ? 16'hffff : r.addr[0] ? 16'hff00 : 16'h00ff,
        (r.is_mem ? r.addr[15:0] ^ 16'ha5c3 : r.addr[15:0] ^ 16'h3c5a)});
    @(posedge ref_clk);
    #1;
    cmp("status", {1'b0, ie, r.seg}, upper_addr_status_o);
    cmp("spare", r.cycle_status_bit, high_byte_enable_status_n_o);
    cmp("rd2", 16'h1, read_strobe_n_o);
    if (k == LBC_KIND_READ) cmp("ad_oe2", 16'h0, shared_addr_data_lines_oe);
    if (k == LBC_KIND_WRITE) cmp("wdata", r.wdata, shared_addr_data_lines_o);
    cmp("cyc2", mm ? r.cyc_status : CYC_PASSIVE, cyc_status_o);
  endtask
  // Hold floats the shared, upper, enable and strobe pins
  task automatic hold;
    @(posedge ref_clk);
    while (req_ready !== 1'b1) @(posedge ref_clk);
    hold_ack <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    cmp("hold_oe", 16'h0, {shared_addr_data_lines_oe, upper_addr_status_oe,
      high_byte_enable_status_oe, read_strobe_oe});
    @(posedge ref_clk);
    hold_ack <= 1'b0;
  endtask
  // Result watcher takes the oldest note off the queue
  always @(posedge ref_clk) begin
    if (rdata_valid === 1'b1) begin
      if (exp_q.size() == 0) cmp("rdata_extra", 16'h0, 16'h1);
      else begin
        note = exp_q.pop_front();
        cmp("rdata", note[15:0] & note[31:16], rdata & note[31:16]);
      end
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    #500000;
    errors++;
    end_sim();
  end
  initial begin
    seed = 99929;
    {resetn, req_valid, int_enable_flag, hold_ack, max_mode, waits} = '0;
    req = '0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (120) begin
      op(lbc_kind_t'($unsigned($random(seed)) % 4 == 3 ? 2 : $unsigned($random(seed)) % 2));
      if ($random(seed) % 5 == 0) hold();
    end
    repeat (10) @(posedge ref_clk);
    cmp("left", 16'h0, exp_q.size());
    end_sim();
  end
endmodule
